/* bench/two_wire_bus_engine_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_engine_bench;
  logic       mclk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic       sc_wr = 1'b0;
  logic       tc_wr = 1'b0;
  logic       tx_valid = 1'b0;
  logic       rx_ready = 1'b0;
  logic [7:0] sc_data = 8'h00;
  logic [7:0] tc_data = 8'h00;
  logic [7:0] count = 8'h00;
  logic [7:0] tx_data = 8'h00;
  logic [9:0] target = 10'h05a;
  logic [7:0] serial_ctrl, transfer_ctrl, data_ctrl, rx_data;
  logic       tx_ready, rx_valid, busy, scl_o, scl_oe, sda_o, sda_oe, slv_oe;
  wire logic  scl_w = ~scl_oe;
  wire logic  sda_w = ~(sda_oe | slv_oe);
  int         num_errors = 0;
  int         n_compared = 0;
  int         base;
  int         n;
  always #12.5 mclk_in = ~mclk_in;
  two_wire_bus_engine dut (
    .mclk_in(mclk_in), .resetn_in(resetn_in),
    .serial_ctrl_wr_in(sc_wr), .serial_ctrl_data_in(sc_data),
    .serial_ctrl_out(serial_ctrl), .transfer_ctrl_wr_in(tc_wr),
    .transfer_ctrl_data_in(tc_data), .transfer_ctrl_out(transfer_ctrl),
    .data_ctrl_out(data_ctrl), .byte_count_in(count),
    .clock_prescaler_in(8'h00), .scl_low_period_in(8'h03),
    .scl_high_period_in(8'h03), .target_address_in(target),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready),
    .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready),
    .bus_busy_flag_out(busy), .scl_in(scl_w), .scl_out(scl_o),
    .scl_oe_out(scl_oe), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_out(sda_oe)
  );
  two_wire_slave_model slave (
    .scl_in(scl_w), .sda_in(sda_w), .sda_oe_out(slv_oe)
  );
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic tc, input logic [7:0] v);
    @(posedge mclk_in);
    sc_wr <= !tc;
    tc_wr <= tc;
    sc_data <= v;
    tc_data <= v;
    @(posedge mclk_in);
    sc_wr <= 1'b0;
    tc_wr <= 1'b0;
  endtask
  task automatic push(input logic [7:0] v);
    @(posedge mclk_in);
    tx_valid <= 1'b1;
    tx_data <= v;
    @(negedge mclk_in);
    while (tx_ready !== 1'b1) @(negedge mclk_in);
    @(posedge mclk_in);
    tx_valid <= 1'b0;
  endtask
  task automatic wait_busy(input logic lvl);
    for (int k = 0; k < 20000 && busy !== lvl; k++) @(negedge mclk_in);
    check("busy", busy, lvl);
    repeat (6) @(negedge mclk_in);
  endtask
  task automatic wait_got(input int cnt);
    for (int k = 0; k < 20000 && !(slave.got.size() >= cnt &&
         data_ctrl[1] === 1'b1); k++) @(negedge mclk_in);
    check("hold", data_ctrl[1], 1'b1);
  endtask
  task automatic take(input logic [7:0] exp);
    for (int k = 0; k < 20000 && !(rx_valid === 1'b1 &&
         data_ctrl[1] === 1'b1); k++) @(negedge mclk_in);
    check("rx_data", rx_data, exp);
    check("scl held", scl_oe, 1'b1);
    @(posedge mclk_in);
    rx_ready <= 1'b1;
    @(posedge mclk_in);
    rx_ready <= 1'b0;
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk_in);
    num_errors++;
    complete_run();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(negedge mclk_in);
    check("serial_ctrl", serial_ctrl, two_wire_pkg::SC_RESET);
    check("transfer_ctrl", transfer_ctrl, two_wire_pkg::TC_RESET);
    check("tx_ready", tx_ready, 1'b0);
    check("busy", busy, 1'b0);
    wr(1'b0, 8'h25);
    wr(1'b0, 8'h24);
    wr(1'b0, 8'h26);
    @(negedge mclk_in);
    check("serial_ctrl", serial_ctrl, 8'h26);
    wr(1'b1, 8'h00);
    repeat (60) @(negedge mclk_in);
    check("idle sda", sda_oe, 1'b0);
    wr(1'b1, 8'h23);
    repeat (60) @(negedge mclk_in);
    check("reserved busy", busy, 1'b0);
    wr(1'b1, 8'h00);
    $display("test setup idle reserved done");
    @(posedge mclk_in);
    count <= 8'h08;
    n = 0;
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk_in);
      if (tx_ready === 1'b1) begin
        push(8'h30 + n[7:0]);
        n++;
      end
    end
    check("fifo fill", n, 16'd8);
    base = slave.got.size();
    wr(1'b1, 8'h03);
    wait_busy(1'b1);
    wait_busy(1'b0);
    check("addr7 w", slave.got[base], {target[6:0], 1'b0});
    for (int i = 0; i < 8; i++)
      check("data", slave.got[base + 1 + i], 8'h30 + i[7:0]);
    check("bytes", slave.got.size(), base + 9);
    check("auto stop", transfer_ctrl, 8'h00);
    $display("test counted write done");
    @(posedge mclk_in);
    count <= 8'h01;
    push(8'h77);
    base = slave.got.size();
    wr(1'b1, 8'h01);
    wait_got(base + 2);
    check("no stop", busy, 1'b1);
    check("data", slave.got[base + 1], 8'h77);
    wr(1'b1, 8'h11);
    take(8'ha5);
    wait_got(base + 4);
    wr(1'b1, 8'h12);
    wait_busy(1'b0);
    check("addr7 r", slave.got[base + 2], {target[6:0], 1'b1});
    check("master nack", slave.acks[0], 1'b1);
    check("stop bits", transfer_ctrl[1:0], 2'b00);
    $display("test restart read done");
    @(posedge mclk_in);
    target <= 10'h2c5;
    for (int i = 0; i < 3; i++)
      push(8'hc0 + i[7:0]);
    base = slave.got.size();
    wr(1'b1, 8'h61);
    wait_got(base + 5);
    wr(1'b1, 8'h62);
    wait_busy(1'b0);
    check("addr10 a", slave.got[base],
          {two_wire_pkg::ADDR10_HEAD, target[9:8], 1'b0});
    check("addr10 b", slave.got[base + 1], target[7:0]);
    for (int i = 0; i < 3; i++)
      check("data", slave.got[base + 2 + i], 8'hc0 + i[7:0]);
    check("bytes", slave.got.size(), base + 5);
    check("repeat stop", transfer_ctrl, 8'h60);
    $display("test ten bit repeat done");
    push(8'h99);
    wr(1'b1, 8'h21);
    wait_busy(1'b1);
    wr(1'b0, 8'h00);
    repeat (2) @(negedge mclk_in);
    check("scl off", scl_oe, 1'b0);
    check("sda off", sda_oe, 1'b0);
    check("tc kept", transfer_ctrl, 8'h20);
    check("data_ctrl", data_ctrl, 8'h00);
    check("serial_ctrl", serial_ctrl, 8'h00);
    $display("test disable done");
    wr(1'b0, 8'h01);
    complete_run();
  end
endmodule
`default_nettype wire

/* bench/two_wire_bus_engine_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_engine_sva #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic       mclk_in,
  input wire logic       resetn_in,
  input wire logic [7:0] serial_ctrl_out,
  input wire logic [7:0] transfer_ctrl_out,
  input wire logic [7:0] data_ctrl_out,
  input wire logic       tx_ready_out,
  input wire logic       bus_busy_flag_out,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       scl_out,
  input wire logic       scl_oe_out,
  input wire logic       sda_out,
  input wire logic       sda_oe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire logic run = serial_ctrl_out[1] & serial_ctrl_out[2] & serial_ctrl_out[5];
  logic [7:0] tc;
  assign tc = transfer_ctrl_out;
  // ------------------------------------------------------------
  // Line events
  // ------------------------------------------------------------
  sequence s_start;
    run && scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_stop;
    run && scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  sequence s_quiet;
    !scl_oe_out && !sda_oe_out && !bus_busy_flag_out;
  endsequence
  sequence s_off;
    $fell(serial_ctrl_out[1]);
  endsequence
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_pins_low_only:
    assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin driven high");
  a_off_releases:
    assert property (!serial_ctrl_out[1] [*2] |-> !scl_oe_out && !sda_oe_out)
    else $error("lines held while disabled");
  a_off_no_push:
    assert property (!run [*2] |-> !tx_ready_out)
    else $error("buffer open while disabled");
  a_off_clears_ctrl:
    assert property (s_off |-> ##[0:1] tc[3:0] == 4'h0)
    else $error("low control bits kept");
  a_off_keeps_high:
    assert property (s_off |-> tc[7:4] == $past(tc[7:4]))
    else $error("high control bits lost");
  a_off_clears_data:
    assert property (s_off |-> ##[0:1] data_ctrl_out == 8'h00)
    else $error("data control kept");
  a_busy_on_start:
    assert property (s_start |-> ##[1:6] bus_busy_flag_out)
    else $error("busy not set");
  a_busy_off_stop:
    assert property (s_stop |-> ##[1:6] !bus_busy_flag_out)
    else $error("busy not cleared");
  a_idle_stays_quiet:
    assert property (tc[1:0] == 2'b00 ##0 s_quiet |=> !sda_oe_out && !scl_oe_out)
    else $error("activity while idle");
  a_reserved_no_activity:
    assert property (tc[5] && tc[1:0] == 2'b11 ##0 s_quiet
                     |=> !sda_oe_out && !scl_oe_out)
    else $error("activity on reserved setting");
  a_start_launch:
    assert property (run && tc[0] && !(tc[5] && tc[1]) ##0 s_quiet
                     |=> sda_oe_out && !scl_oe_out)
    else $error("start not issued");
  a_hold_pulls_scl:
    assert property (data_ctrl_out[1] |-> scl_oe_out)
    else $error("hold without clock low");
endmodule
bind two_wire_bus_engine two_wire_bus_engine_sva #(.FIFO_DEPTH(FIFO_DEPTH)) u_sva (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .serial_ctrl_out(serial_ctrl_out),
  .transfer_ctrl_out(transfer_ctrl_out), .data_ctrl_out(data_ctrl_out),
  .tx_ready_out(tx_ready_out), .bus_busy_flag_out(bus_busy_flag_out),
  .scl_in(scl_in), .sda_in(sda_in), .scl_out(scl_out),
  .scl_oe_out(scl_oe_out), .sda_out(sda_out), .sda_oe_out(sda_oe_out)
);
`default_nettype wire

/* bench/two_wire_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module two_wire_slave_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output var logic  sda_oe_out
);
  logic [7:0] sh;
  logic [7:0] txb;
  logic       oe = 1'b0;
  logic       rd = 1'b0;
  logic       adr = 1'b0;
  logic       ten = 1'b0;
  logic       was;
  int         bitn = 0;
  int         ri = 0;
  logic [7:0] got[$];
  logic       acks[$];
  logic [7:0] rdat[2] = '{8'ha5, 8'h3c};
  assign sda_oe_out = oe;
  // ------------------------------------------------------------
  // Framing
  // ------------------------------------------------------------
  always @(negedge sda_in) begin
    if (scl_in === 1'b1) begin
      bitn = -1;
      adr = 1'b1;
      ten = 1'b0;
      oe = 1'b0;
    end
  end
  always @(posedge sda_in) begin
    if (scl_in === 1'b1) begin
      bitn = 0;
      adr = 1'b0;
      rd = 1'b0;
    end
  end
  always @(posedge scl_in) begin
    if (bitn < 8)
      sh = {sh[6:0], sda_in};
    else if (rd && !was)
      acks.push_back(sda_in);
  end
  always @(negedge scl_in) begin
    bitn = bitn + 1;
    if (bitn == 8) begin
      got.push_back(sh);
      was = adr;
      if (adr && !ten)
        rd = sh[0];
      adr = adr && !ten && (sh[7:3] == 5'h1e);
      ten = 1'b1;
      oe = was || !rd;
    end else if (bitn == 9) begin
      bitn = 0;
      oe = 1'b0;
      if (rd && !adr && (was || !acks[$])) begin
        txb = rdat[ri % 2];
        ri = ri + 1;
        oe = !txb[7];
      end
    end else if (rd && !adr) begin
      oe = !txb[7 - bitn];
    end
  end
endmodule
`default_nettype wire

/* rtl/fifo_buffer.sv */
`timescale 1ns/1ps
`default_nettype none
module fifo_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire logic             flush_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } fifo_s;

  fifo_s r_reg;
  fifo_s r_next;
  logic  push;
  logic  pop;

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    push   = in_valid_in && (r_reg.cnt != FULL);
    pop    = out_ready_in && (r_reg.cnt != '0);
    if (push) begin
      r_next.mem[r_reg.wp] = in_data_in;
      r_next.wp = (r_reg.wp == LAST) ? '0 : r_reg.wp + 1'b1;
    end
    if (pop) begin
      r_next.rp = (r_reg.rp == LAST) ? '0 : r_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   r_next.cnt = r_reg.cnt + 1'b1;
      2'b01:   r_next.cnt = r_reg.cnt - 1'b1;
      default: r_next.cnt = r_reg.cnt;
    endcase
    if (flush_in) begin
      r_next = '0;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_ready_out  = (r_reg.cnt != FULL) && !flush_in;
  assign out_valid_out = (r_reg.cnt != '0);
  assign out_data_out  = r_reg.mem[r_reg.rp];

endmodule
`default_nettype wire

/* rtl/two_wire_bus_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_engine #(
  parameter int FIFO_DEPTH = two_wire_pkg::FIFO_DEPTH
) (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       serial_ctrl_wr_in,
  input  wire logic [7:0] serial_ctrl_data_in,
  output logic [7:0]      serial_ctrl_out,
  input  wire logic       transfer_ctrl_wr_in,
  input  wire logic [7:0] transfer_ctrl_data_in,
  output logic [7:0]      transfer_ctrl_out,
  output logic [7:0]      data_ctrl_out,
  input  wire logic [7:0] byte_count_in,
  input  wire logic [7:0] clock_prescaler_in,
  input  wire logic [7:0] scl_low_period_in,
  input  wire logic [7:0] scl_high_period_in,
  input  wire logic [9:0] target_address_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  output logic            bus_busy_flag_out,
  input  wire logic       scl_in,
  output logic            scl_out,
  output logic            scl_oe_out,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out
);

  typedef struct packed {
    two_wire_pkg::state_e st;
    two_wire_pkg::phase_e ph;
    logic [7:0]           sc;
    logic [7:0]           tc;
    logic [1:0]           dc;
    logic [7:0]           psc;
    logic [7:0]           per;
    logic [3:0]           bitn;
    logic [7:0]           txs;
    logic [7:0]           rxs;
    logic [7:0]           rxd;
    logic                 rxv;
    logic [7:0]           done;
    logic                 scl_oe;
    logic                 sda_oe;
    logic [1:0]           scl_s;
    logic [1:0]           sda_s;
    logic                 scl_p;
    logic                 sda_p;
    logic                 busy;
  } engine_s;

  localparam engine_s RST_S = '{
    st: two_wire_pkg::ST_IDLE, ph: two_wire_pkg::PH_A1,
    sc: two_wire_pkg::SC_RESET, tc: two_wire_pkg::TC_RESET,
    default: '0};

  engine_s    r_reg;
  engine_s    r_next;
  logic       run;
  logic       tick;
  logic       low_due;
  logic       high_due;
  logic       scl_hi;
  logic       sda_hi;
  logic       rm;
  logic       stt;
  logic       stp;
  logic       xmit;
  logic       last;
  logic       counted;
  logic       pop;
  logic       fifo_valid;
  logic [7:0] fifo_data;
  logic [7:0] addr1;

  // ----------------------------------------------------------------
  // Transmit data buffer
  // ----------------------------------------------------------------
  fifo_buffer #(
    .WIDTH (two_wire_pkg::DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk_in       (mclk_in),
    .resetn_in     (resetn_in),
    .flush_in      (!run),
    .in_valid_in   (tx_valid_in),
    .in_data_in    (tx_data_in),
    .in_ready_out  (tx_ready_out),
    .out_valid_out (fifo_valid),
    .out_ready_in  (pop),
    .out_data_out  (fifo_data)
  );

  // ----------------------------------------------------------------
  // Engine state
  // ----------------------------------------------------------------
  always_comb begin
    r_next  = r_reg;
    pop     = 1'b0;
    run     = r_reg.sc[two_wire_pkg::SC_ENABLE] &&
              r_reg.sc[two_wire_pkg::SC_SYNC] &&
              r_reg.sc[two_wire_pkg::SC_TWO_WIRE];
    rm      = r_reg.tc[two_wire_pkg::TC_REPEAT];
    stt     = r_reg.tc[two_wire_pkg::TC_START];
    stp     = r_reg.tc[two_wire_pkg::TC_STOP];
    scl_hi  = r_reg.scl_s[1];
    sda_hi  = r_reg.sda_s[1];
    tick    = (r_reg.psc == clock_prescaler_in);
    low_due  = tick && (r_reg.per >= scl_low_period_in);
    high_due = tick && (r_reg.per >= scl_high_period_in) && scl_hi;
    xmit    = (r_reg.ph != two_wire_pkg::PH_DATA) ||
              !r_reg.tc[two_wire_pkg::TC_DIR];
    last    = !rm && ((r_reg.done + 8'h01) >= byte_count_in);
    counted = !rm && (r_reg.done >= byte_count_in);
    addr1   = r_reg.tc[two_wire_pkg::TC_XA] ?
              {two_wire_pkg::ADDR10_HEAD, target_address_in[9:8],
               r_reg.tc[two_wire_pkg::TC_DIR]} :
              {target_address_in[6:0],
               r_reg.tc[two_wire_pkg::TC_DIR]};

    // Line sampling and bus busy
    r_next.scl_s = {r_reg.scl_s[0], scl_in};
    r_next.sda_s = {r_reg.sda_s[0], sda_in};
    r_next.scl_p = scl_hi;
    r_next.sda_p = sda_hi;
    if (scl_hi && r_reg.scl_p && r_reg.sda_p && !sda_hi) begin
      r_next.busy = 1'b1;
    end
    if (scl_hi && r_reg.scl_p && !r_reg.sda_p && sda_hi) begin
      r_next.busy = 1'b0;
    end

    // Bit timer
    r_next.psc = tick ? 8'h00 : r_reg.psc + 8'h01;
    if (tick) begin
      r_next.per = r_reg.per + 8'h01;
    end
    if (r_reg.st == two_wire_pkg::ST_HIGH && !scl_hi) begin
      r_next.per = 8'h00;
    end

    if (r_reg.rxv && rx_ready_in) begin
      r_next.rxv = 1'b0;
    end

    case (r_reg.st)
      two_wire_pkg::ST_IDLE: begin
        r_next.scl_oe = 1'b0;
        r_next.sda_oe = 1'b0;
        if (stt && !(rm && stp) && !r_reg.busy) begin
          r_next.st     = two_wire_pkg::ST_START;
          r_next.sda_oe = 1'b1;
          r_next.tc[two_wire_pkg::TC_START] = 1'b0;
          r_next.per    = 8'h00;
          r_next.txs    = addr1;
          r_next.ph     = two_wire_pkg::PH_A1;
          r_next.bitn   = 4'h0;
          r_next.done   = 8'h00;
        end else if (stp && !stt) begin
          r_next.tc[two_wire_pkg::TC_STOP] = 1'b0;
        end
      end
      two_wire_pkg::ST_START: begin
        if (high_due) begin
          r_next.st     = two_wire_pkg::ST_LOW;
          r_next.scl_oe = 1'b1;
          r_next.per    = 8'h00;
        end
      end
      two_wire_pkg::ST_LOW: begin
        if (tick && r_reg.per == 8'h00) begin
          if (r_reg.bitn == two_wire_pkg::BIT_ACK) begin
            r_next.sda_oe = !xmit && !last;
          end else begin
            r_next.sda_oe = xmit && !r_reg.txs[7];
          end
        end
        if (low_due) begin
          r_next.st     = two_wire_pkg::ST_HIGH;
          r_next.scl_oe = 1'b0;
          r_next.per    = 8'h00;
        end
      end
      two_wire_pkg::ST_HIGH: begin
        if (high_due) begin
          r_next.scl_oe = 1'b1;
          r_next.per    = 8'h00;
          if (r_reg.bitn != two_wire_pkg::BIT_ACK) begin
            r_next.rxs  = {r_reg.rxs[6:0], sda_hi};
            r_next.txs  = {r_reg.txs[6:0], 1'b0};
            r_next.bitn = r_reg.bitn + 4'h1;
            r_next.st   = two_wire_pkg::ST_LOW;
          end else begin
            r_next.dc[two_wire_pkg::DC_NACK] = xmit && sda_hi;
            r_next.bitn = 4'h0;
            r_next.st   = two_wire_pkg::ST_HOLD;
            if (r_reg.ph == two_wire_pkg::PH_DATA) begin
              r_next.done = r_reg.done + 8'h01;
              if (!xmit) begin
                r_next.rxd = r_reg.rxs;
                r_next.rxv = 1'b1;
              end
            end
          end
        end
      end
      two_wire_pkg::ST_HOLD: begin
        r_next.scl_oe = 1'b1;
        r_next.per    = 8'h00;
        if (rm && stp && stt) begin
          r_next.st = two_wire_pkg::ST_HOLD;
        end else if (r_reg.ph == two_wire_pkg::PH_A1 &&
                     r_reg.tc[two_wire_pkg::TC_XA]) begin
          r_next.txs = target_address_in[7:0];
          r_next.ph  = two_wire_pkg::PH_A2;
          r_next.st  = two_wire_pkg::ST_LOW;
        end else if (stp && (rm || counted)) begin
          r_next.st = two_wire_pkg::ST_SP_LOW;
        end else if (stt) begin
          r_next.st = two_wire_pkg::ST_RS_LOW;
        end else if (counted) begin
          r_next.st = two_wire_pkg::ST_HOLD;
        end else if (xmit || r_reg.ph != two_wire_pkg::PH_DATA) begin
          if (!r_reg.tc[two_wire_pkg::TC_DIR]) begin
            if (fifo_valid) begin
              pop        = 1'b1;
              r_next.txs = fifo_data;
              r_next.ph  = two_wire_pkg::PH_DATA;
              r_next.st  = two_wire_pkg::ST_LOW;
            end
          end else if (!r_reg.rxv) begin
            r_next.ph = two_wire_pkg::PH_DATA;
            r_next.st = two_wire_pkg::ST_LOW;
          end
        end else if (!r_reg.rxv) begin
          r_next.st = two_wire_pkg::ST_LOW;
        end
      end
      two_wire_pkg::ST_SP_LOW: begin
        if (tick && r_reg.per == 8'h00) begin
          r_next.sda_oe = 1'b1;
        end
        if (low_due) begin
          r_next.st     = two_wire_pkg::ST_SP_HIGH;
          r_next.scl_oe = 1'b0;
          r_next.per    = 8'h00;
        end
      end
      two_wire_pkg::ST_SP_HIGH: begin
        if (!scl_hi) begin
          r_next.per = 8'h00;
        end else if (high_due) begin
          r_next.st     = two_wire_pkg::ST_SP_END;
          r_next.sda_oe = 1'b0;
          r_next.per    = 8'h00;
        end
      end
      two_wire_pkg::ST_SP_END: begin
        if (high_due) begin
          r_next.st = two_wire_pkg::ST_IDLE;
          r_next.tc[two_wire_pkg::TC_STOP] = 1'b0;
          r_next.tc[two_wire_pkg::TC_START] = 1'b0;
        end
      end
      two_wire_pkg::ST_RS_LOW: begin
        if (tick && r_reg.per == 8'h00) begin
          r_next.sda_oe = 1'b0;
        end
        if (low_due) begin
          r_next.st     = two_wire_pkg::ST_RS_HIGH;
          r_next.scl_oe = 1'b0;
          r_next.per    = 8'h00;
        end
      end
      two_wire_pkg::ST_RS_HIGH: begin
        if (!scl_hi) begin
          r_next.per = 8'h00;
        end else if (high_due) begin
          r_next.st     = two_wire_pkg::ST_START;
          r_next.sda_oe = 1'b1;
          r_next.tc[two_wire_pkg::TC_START] = 1'b0;
          r_next.per    = 8'h00;
          r_next.txs    = addr1;
          r_next.ph     = two_wire_pkg::PH_A1;
          r_next.done   = 8'h00;
        end
      end
      default: begin
        r_next.st = two_wire_pkg::ST_IDLE;
      end
    endcase
    r_next.dc[two_wire_pkg::DC_HOLD] =
      (r_next.st == two_wire_pkg::ST_HOLD);

    // Disabled engine
    if (!run) begin
      r_next.st     = two_wire_pkg::ST_IDLE;
      r_next.scl_oe = 1'b0;
      r_next.sda_oe = 1'b0;
      r_next.tc     = r_reg.tc & two_wire_pkg::TC_KEEP;
      r_next.dc     = 2'h0;
      r_next.rxd    = 8'h00;
      r_next.rxv    = 1'b0;
      r_next.txs    = 8'h00;
      r_next.rxs    = 8'h00;
      r_next.bitn   = 4'h0;
      r_next.done   = 8'h00;
    end

    // Software writes win over hardware clears; while disabled, transfer control bits 3-0 stay clear
    if (transfer_ctrl_wr_in) begin
      r_next.tc = run ? transfer_ctrl_data_in :
                  (transfer_ctrl_data_in & two_wire_pkg::TC_KEEP);
    end
    if (serial_ctrl_wr_in) begin
      r_next.sc = serial_ctrl_data_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      r_reg <= RST_S;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_ctrl_out   = r_reg.sc;
  assign transfer_ctrl_out = r_reg.tc;
  assign data_ctrl_out     = {6'h00, r_reg.dc};
  assign rx_data_out       = r_reg.rxd;
  assign rx_valid_out      = r_reg.rxv;
  assign bus_busy_flag_out = r_reg.busy;
  assign scl_out           = 1'b0;
  assign sda_out           = 1'b0;
  assign scl_oe_out        = r_reg.scl_oe;
  assign sda_oe_out        = r_reg.sda_oe;

endmodule
`default_nettype wire

/* rtl/two_wire_pkg.sv */
// Notes on behaviour
// - One SCL pulse per data bit; bytes leave and arrive MSB first.
// - First byte after START is 7-bit address plus direction; 0 writes, 1 reads.
// - Receiver answers each byte on the ninth clock; as receiver, the master NACKs the last counted byte.
// - START is SDA falling, STOP SDA rising, with SCL high; else SDA moves low.
// - Busy flag sets on a seen START and clears on a seen STOP.
// - 10-bit first byte is 11110, two upper bits, direction; then low eight bits.
// - Master can issue a repeated START and resend address with new direction.
// - Master holds SCL low after a byte while software service is needed.
// - Start and stop requests both clear keeps the master idle.
// - Repeat off, start only: transfer of byte count bytes, no automatic STOP.
// - Repeat off, start and stop: STOP follows automatically after byte count.
// - Repeat on ignores byte count; software ends transfer with stop request.
// - Repeat off, stop only: STOP after byte count bytes, or at once.
// - Repeat, stop and start all set is reserved: no bus activity.
// - Clearing enable stops communication and releases SDA and SCL.
// - Clearing enable clears transfer control bits 3-0, data control, data, shifts.
// - Clearing enable keeps serial control, count, timing and address settings.
// - Serial control resets to asynchronous mode; two-wire needs sync and mode bits.
// - Each node has a unique address; only the master starts and clocks.
package two_wire_pkg;

  // ----------------------------------------------------------------
  // Serial control fields
  // ----------------------------------------------------------------
  localparam int        SC_SOFT_RST = 0;
  localparam int        SC_ENABLE   = 1;
  localparam int        SC_SYNC     = 2;
  localparam int        SC_TWO_WIRE = 5;
  localparam logic [7:0] SC_RESET   = 8'h01;

  // ----------------------------------------------------------------
  // Transfer control fields
  // ----------------------------------------------------------------
  localparam int        TC_START    = 0;
  localparam int        TC_STOP     = 1;
  localparam int        TC_DIR      = 4;
  localparam int        TC_REPEAT   = 5;
  localparam int        TC_XA       = 6;
  localparam logic [7:0] TC_RESET   = 8'h00;
  localparam logic [7:0] TC_KEEP    = 8'hf0;

  // ----------------------------------------------------------------
  // Data control fields
  // ----------------------------------------------------------------
  localparam int        DC_NACK     = 0;
  localparam int        DC_HOLD     = 1;

  // ----------------------------------------------------------------
  // Framing and timing
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR10_HEAD = 5'h1e;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam int         FIFO_DEPTH  = 8;
  localparam int         DATA_W      = 8;
  localparam logic [7:0] PSC_DEF     = 8'h00;
  localparam logic [7:0] SCLL_DEF    = 8'h09;
  localparam logic [7:0] SCLH_DEF    = 8'h09;

  typedef enum logic [1:0] {
    PH_A1   = 2'h0,
    PH_A2   = 2'h1,
    PH_DATA = 2'h3
  } phase_e;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_START   = 4'h1,
    ST_LOW     = 4'h3,
    ST_HIGH    = 4'h2,
    ST_HOLD    = 4'h6,
    ST_SP_LOW  = 4'h7,
    ST_SP_HIGH = 4'h5,
    ST_SP_END  = 4'h4,
    ST_RS_LOW  = 4'hc,
    ST_RS_HIGH = 4'hd
  } state_e;

endpackage
